// ===== hw/flash_adc_converter.sv
`timescale 1ns/10ps
`include "flash_adc_defines.svh"
// Contract
// - Clock high auto-zero, low samples input.
// - Sampling latches 128 comparators, encodes seven bits.
// - Rising clock loads encoder into output latch.
// - Host gives high, low, high per conversion.
// - One new sample every full clock period.
// - Group select low floats all eight outputs.
// - Data select high floats data, overflow driven.
// - Straight binary, bit1 MSB, full scale 7F.
// - Overflow sets flag, data stays all ones.
// - Cascade: overflow swaps which device drives data.
// - Cascade: overflow is combined result MSB.
// - Sampling low portion near 12 ns recommended.
// - Below 100 kHz shorten sampling portion.
// - Sampling low portion at least 12 ns.
module flash_adc_converter #(
  parameter int THERM_W = `ADC_THERM_W
) (
  input  wire logic                 ref_clk_i,
  input  wire logic                 sys_rst_i,
  input  wire logic [THERM_W-1:0]   comparators_i,
  output logic                      phase_sample_o,
  output logic                      loaded_o,
  flash_adc_if.converter            adc
);
  logic [THERM_W-1:0]           therm;
  logic                         clk_prev;
  logic [`ADC_DATA_W-1:0]       out_code;
  logic                         out_ovf;
  logic [`ADC_DATA_W-1:0]       enc_code;
  logic                         enc_ovf;

  // Count of ones; tolerant of thermometer bubbles, unlike a priority encoder
  function automatic logic [7:0] ones_count(input logic [THERM_W-1:0] t);
    logic [7:0] n;
    n = 8'h00;
    for (int i = 0; i < THERM_W; i++) begin
      n = n + {7'h00, t[i]};
    end
    return n;
  endfunction : ones_count

  ////////////////////////////////////////////////////////////////////
  assign phase_sample_o = ~adc.conv_clk;

  // Comparators land in latches only while the clock is low
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      therm    <= '0;
      clk_prev <= 1'b1;
    end else begin
      clk_prev <= adc.conv_clk;
      if (!adc.conv_clk) begin
        therm <= comparators_i;
      end
    end
  end

  // Top comparator is overflow; data saturates at all ones
  always_comb begin
    logic [7:0] n;
    n = ones_count(therm);
    enc_ovf = therm[THERM_W-1];
    if (enc_ovf || n >= 8'(THERM_W - 1)) begin
      enc_code = `ADC_FULL_SCALE;
    end else begin
      enc_code = n[`ADC_DATA_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Loads on every rising clock regardless of the selects
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      out_code <= `ADC_DATA_RESET;
      out_ovf  <= 1'b0;
      loaded_o <= 1'b0;
    end else begin
      loaded_o <= adc.conv_clk && !clk_prev;
      if (adc.conv_clk && !clk_prev) begin
        out_code <= enc_code;
        out_ovf  <= enc_ovf;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Enables are active low; selects gate pins only
  assign adc.data_out      = out_code;
  assign adc.overflow_out  = out_ovf;
  assign adc.data_oe_n     = {`ADC_DATA_W{~(adc.output_group_select &
                               ~adc.data_bits_select_n)}};
  assign adc.overflow_oe_n = ~adc.output_group_select;
endmodule : flash_adc_converter

// ===== hw/flash_adc_defines.svh
`ifndef FLASH_ADC_DEFINES_SVH
`define FLASH_ADC_DEFINES_SVH

`define ADC_DATA_W        7
`define ADC_THERM_W       128
`define ADC_FULL_SCALE    7'h7F
`define ADC_DATA_RESET    7'h00
`define ADC_SAMPLE_MIN_NS 12
`define ADC_CLK_PERIOD_NS 5
`define ADC_SAMPLE_MIN_CYC ((`ADC_SAMPLE_MIN_NS + `ADC_CLK_PERIOD_NS - 1) / `ADC_CLK_PERIOD_NS)
`define ADC_HIGH_CYC      3

`endif

// ===== hw/flash_adc_host.sv
`timescale 1ns/10ps
`include "flash_adc_defines.svh"
module flash_adc_host #(
  parameter int SAMPLE_CYC = `ADC_SAMPLE_MIN_CYC,
  parameter int HIGH_CYC   = `ADC_HIGH_CYC
) (
  input  wire logic       ref_clk_i,
  input  wire logic       sys_rst_i,
  input  wire logic       start_i,
  input  wire logic       continuous_i,
  input  wire logic       data_bits_select_n_i,
  input  wire logic       output_group_select_i,
  output logic            busy_o,
  output logic            result_valid_o,
  output logic [6:0]      result_o,
  output logic            overflow_o,
  flash_adc_if.host       adc
);
  flash_adc_pkg::host_state_type state;
  logic [7:0] cnt;
  logic       conv_clk;
  logic       was_sampled;
  logic       capture;

  ////////////////////////////////////////////////////////////////////
  assign adc.conv_clk            = conv_clk;
  assign adc.data_bits_select_n  = data_bits_select_n_i;
  assign adc.output_group_select = output_group_select_i;
  assign busy_o                  = (state != flash_adc_pkg::HOST_IDLE);

  // High, low for at least 12 ns, high again: one conversion
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      state       <= flash_adc_pkg::HOST_IDLE;
      cnt         <= 8'h00;
      conv_clk    <= 1'b1;
      was_sampled <= 1'b0;
    end else begin
      case (state)
        flash_adc_pkg::HOST_IDLE: begin
          conv_clk <= 1'b1;
          cnt      <= 8'h00;
          if (start_i || continuous_i) begin
            state <= flash_adc_pkg::HOST_HIGH;
          end
        end
        flash_adc_pkg::HOST_HIGH: begin
          if (cnt >= 8'(HIGH_CYC - 1)) begin
            cnt      <= 8'h00;
            conv_clk <= 1'b0;
            state    <= flash_adc_pkg::HOST_SAMPLE;
          end else begin
            cnt <= cnt + 8'h01;
          end
        end
        flash_adc_pkg::HOST_SAMPLE: begin
          // Short low phase helps aperture, but never below the minimum
          if (cnt >= 8'(SAMPLE_CYC - 1)) begin
            cnt         <= 8'h00;
            conv_clk    <= 1'b1;
            was_sampled <= 1'b1;
            state       <= flash_adc_pkg::HOST_DONE;
          end else begin
            cnt <= cnt + 8'h01;
          end
        end
        flash_adc_pkg::HOST_DONE: begin
          // Result is read two cycles into the final high level
          if (continuous_i) begin
            state <= flash_adc_pkg::HOST_HIGH;
            cnt   <= 8'h01;
          end else begin
            state <= flash_adc_pkg::HOST_IDLE;
          end
        end
        default: state <= flash_adc_pkg::HOST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // The latch loads at the edge that leaves DONE, so read one edge later
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      capture <= 1'b0;
    end else begin
      capture <= (state == flash_adc_pkg::HOST_DONE);
    end
  end

  // Capture what the converter drives; floating bits read as zero
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      result_valid_o <= 1'b0;
      result_o       <= `ADC_DATA_RESET;
      overflow_o     <= 1'b0;
    end else begin
      result_valid_o <= capture && was_sampled;
      if (capture) begin
        result_o   <= adc.data_out & ~adc.data_oe_n;
        overflow_o <= adc.overflow_out & ~adc.overflow_oe_n;
      end
    end
  end
endmodule : flash_adc_host

// ===== hw/flash_adc_if.sv
`timescale 1ns/10ps
interface flash_adc_if;
  logic       conv_clk;
  logic       data_bits_select_n;
  logic       output_group_select;
  logic [6:0] data_out;
  logic [6:0] data_oe_n;
  logic       overflow_out;
  logic       overflow_oe_n;

  modport converter (
    input  conv_clk, data_bits_select_n, output_group_select,
    output data_out, data_oe_n, overflow_out, overflow_oe_n
  );
  modport host (
    output conv_clk, data_bits_select_n, output_group_select,
    input  data_out, data_oe_n, overflow_out, overflow_oe_n
  );
endinterface : flash_adc_if

// ===== hw/flash_adc_pkg.sv
package flash_adc_pkg;
  typedef logic [6:0]   code_type;
  typedef logic [127:0] therm_type;
  typedef enum logic [3:0] {
    HOST_IDLE   = 4'h1,
    HOST_HIGH   = 4'h2,
    HOST_SAMPLE = 4'h4,
    HOST_DONE   = 4'h8
  } host_state_type;
endpackage : flash_adc_pkg

// ===== verif/flash_adc_output_pipeline_test.sv
`timescale 1ns/10ps
`include "flash_adc_defines.svh"
module flash_adc_output_pipeline_test;
  logic ref_clk = 1'b0, sys_rst = 1'b1, start = 1'b0, cont = 1'b0, sel_n = 1'b0, grp = 1'b1;
  logic busy, valid, loaded, phase, ovf;
  flash_adc_pkg::code_type  result;
  flash_adc_pkg::therm_type comps = '0;
  int miscompares = 0, n_tests = 0, cycles = 0, k, n;
  int codes[7] = '{0, 1, 32, 63, 64, 127, 128};
  flash_adc_if adc ();
  flash_adc_host flash_adc_host_inst (.ref_clk_i(ref_clk), .sys_rst_i(sys_rst),
    .start_i(start), .continuous_i(cont), .data_bits_select_n_i(sel_n),
    .output_group_select_i(grp), .busy_o(busy), .result_valid_o(valid),
    .result_o(result), .overflow_o(ovf), .adc(adc));
  flash_adc_converter flash_adc_converter_inst (.ref_clk_i(ref_clk), .sys_rst_i(sys_rst),
    .comparators_i(comps), .phase_sample_o(phase), .loaded_o(loaded), .adc(adc));
  flash_adc_properties flash_adc_properties_inst (.ref_clk_i(ref_clk), .sys_rst_i(sys_rst),
    .conv_clk(adc.conv_clk), .data_bits_select_n(adc.data_bits_select_n),
    .output_group_select(adc.output_group_select), .data_out(adc.data_out),
    .data_oe_n(adc.data_oe_n), .overflow_out(adc.overflow_out),
    .overflow_oe_n(adc.overflow_oe_n));
  ////////////////////////////////////////////////////////////////////////////
  initial forever #2.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 2000) begin
      miscompares++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("tests %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict
  task automatic check1(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : check1
  // Bounded so a latch that never loads ends in a mismatch, not a hang
  task automatic wait_load(output int cnt);
    cnt = 0;
    do begin
      @(posedge ref_clk);
      #1;
      cnt++;
    end while (loaded !== 1'b1 && cnt < 40);
  endtask : wait_load
  task automatic convert(input int ones, output int cnt);
    @(posedge ref_clk);
    comps <= (ones > 127) ? '1 : ((128'h1 << ones) - 128'h1);
    start <= 1'b1;
    @(posedge ref_clk);
    start <= 1'b0;
    #1;
    check1(8'({busy, phase}), 8'h02, "busy in auto-zero");
    wait_load(cnt);
  endtask : convert
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge ref_clk);
    sys_rst <= 1'b0;
    for (k = 0; k < 7; k++) begin
      convert(codes[k], n);
      check1({adc.overflow_out, adc.data_out}, (codes[k] > 127) ? 8'hFF : 8'(codes[k]),
        "code");
      check1(8'(n), 8'(`ADC_HIGH_CYC + `ADC_SAMPLE_MIN_CYC + 1), "latency");
      @(posedge ref_clk);
      #1;
      check1({ovf, result}, (codes[k] > 127) ? 8'hFF : 8'(codes[k]), "host result");
      check1(8'(valid), 8'h01, "host valid");
    end
    // Last code overflowed: its flag turns this device's data off
    @(posedge ref_clk);
    sel_n <= adc.overflow_out;
    @(posedge ref_clk);
    #1;
    check1({adc.overflow_oe_n, adc.data_oe_n}, 8'h7F, "cascade off");
    check1(8'(adc.overflow_out), 8'h01, "cascade msb");
    for (k = 0; k < 4; k++) begin
      @(posedge ref_clk);
      {grp, sel_n} <= 2'(k);
      @(posedge ref_clk);
      #1;
      check1({adc.overflow_oe_n, adc.data_oe_n}, (k < 2) ? 8'hFF : ((k == 2) ? 8'h00 : 8'h7F),
        "enables");
    end
    // Latch must keep converting with every output floated
    @(posedge ref_clk);
    grp <= 1'b0;
    convert(64, n);
    check1({adc.overflow_out, adc.data_out}, 8'h40, "floated load");
    @(posedge ref_clk);
    #1;
    check1({ovf, result}, 8'h00, "floated host read");
    @(posedge ref_clk);
    cont <= 1'b1;
    wait_load(n);
    wait_load(n);
    check1(8'(n), 8'(`ADC_HIGH_CYC + `ADC_SAMPLE_MIN_CYC), "period");
    give_verdict();
  end
endmodule : flash_adc_output_pipeline_test

// ===== verif/flash_adc_properties.sv
`timescale 1ns/10ps
module flash_adc_properties (
  input wire logic       ref_clk_i,
  input wire logic       sys_rst_i,
  input wire logic       conv_clk,
  input wire logic       data_bits_select_n,
  input wire logic       output_group_select,
  input wire logic [6:0] data_out,
  input wire logic [6:0] data_oe_n,
  input wire logic       overflow_out,
  input wire logic       overflow_oe_n
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  ////////////////////////////////////////////////////////////////////////////
  // Latch moves only the edge after a rising clock was sampled
  sequence load_edge;
    $past(conv_clk) && !$past(conv_clk, 2);
  endsequence
  chk_data_on_rise: assert property ($changed(data_out) |-> load_edge)
    else $error("data latch moved off a rising clock");
  chk_ovf_on_rise: assert property ($changed(overflow_out) |-> load_edge)
    else $error("overflow latch moved off a rising clock");
  chk_ovf_all_ones: assert property (overflow_out |-> data_out == 7'h7F)
    else $error("overflow without all ones");
  chk_group_floats: assert property (!output_group_select
    |-> data_oe_n == 7'h7F && overflow_oe_n)
    else $error("outputs driven with group off");
  chk_data_driven: assert property (output_group_select && !data_bits_select_n
    |-> data_oe_n == 7'h00 && !overflow_oe_n)
    else $error("outputs not driven when selected");
  chk_data_floats: assert property (output_group_select && data_bits_select_n
    |-> data_oe_n == 7'h7F && !overflow_oe_n)
    else $error("data select off handled wrongly");
  chk_sample_span: assert property ($fell(conv_clk) |-> !conv_clk [*3])
    else $error("sampling portion too short");
  chk_high_span: assert property ($rose(conv_clk) |-> conv_clk [*3])
    else $error("auto-zero portion too short");
  ////////////////////////////////////////////////////////////////////////////
  cov_overflow: cover property (overflow_out);
  cov_driven: cover property (data_oe_n == 7'h00);
  cov_load: cover property ($changed(data_out));
endmodule : flash_adc_properties
